// ==== rtl/loop_status_pkg.sv ====
package loop_status_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	// word indices; each byte address is four times its index
	localparam logic [9:0] STATUS_WORD_INDEX = 10'h01F;
	localparam logic [9:0] THRESH_CFG_INDEX = 10'h01A;
	localparam logic [11:0] STATUS_WORD_ADDR = {STATUS_WORD_INDEX, 2'b00};
	localparam logic [11:0] THRESH_CFG_ADDR = {THRESH_CFG_INDEX, 2'b00};
	localparam logic [11:0] IRQ_STATUS_ADDR = 12'h100;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h104;

	// ----------------------------------------
	// status word fields and threshold select bit
	// ----------------------------------------
	localparam int CAL_DONE_BIT = 6;
	localparam int HOLDOVER_BIT = 5;
	localparam int SEC_REF_BIT = 4;
	localparam int VCO_HIGH_BIT = 3;
	localparam int SEC_FREQ_BIT = 2;
	localparam int THRESH_SEL_BIT = 6;
	localparam int STATUS_W = 8;
	localparam logic [7:0] EVENT_FIELDS = 8'h7C;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] THRESH_RESET = 8'h00;

	typedef struct packed {
		logic cal_done;
		logic holdover_active;
		logic secondary_ref_in_use;
		logic vco_above;
		logic sec_freq_above;
	} loop_src_type;

	typedef struct packed {
		logic [STATUS_W-1:0] live;
		logic [STATUS_W-1:0] sticky;
		logic [STATUS_W-1:0] mask;
		logic [STATUS_W-1:0] thresh_cfg;
		logic [31:0] prdata;
		logic irq;
	} regs_type;

endpackage : loop_status_pkg

// ==== rtl/status_event_cell.sv ====
`timescale 1ns/1ps
module status_event_cell
	import loop_status_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] now_i,
	input wire logic [WIDTH-1:0] last_i,
	input wire logic [WIDTH-1:0] sticky_i,
	input wire logic clear_i,
	output logic [WIDTH-1:0] sticky_nxt_o
);
	// ----------------------------------------
	// any change of a status bit is an event; set wins over clear
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_comb begin
				sticky_nxt_o[g] = (sticky_i[g] & ~clear_i)
					| (EVENT_FIELDS[g] & (now_i[g] ^ last_i[g]));
			end
		end
	endgenerate
endmodule : status_event_cell

// ==== rtl/loop_status_word.sv ====
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
// What this block does
// - calibration-done bit reads one after calibration
// - calibration-done at bit 6, zero until done
// - bit 5 reads one while holdover is active
// - holdover bit follows live state, not enable
// - bit 4 one when secondary reference used
// - bit 3 one when VCO above threshold
// - bit 2 secondary frequency above selected threshold
module loop_status_word
	import loop_status_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic CAL_DONE_I,
	input wire logic HOLDOVER_ACTIVE_I,
	input wire logic SECONDARY_REF_IN_USE_I,
	input wire logic VCO_ABOVE_I,
	input wire logic SEC_FREQ_ABOVE_I,
	output logic THRESH_SEL_O,
	output logic IRQ_O
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	regs_type r;
	regs_type r_nxt;
	loop_src_type src;
	logic [STATUS_W-1:0] now_word;
	logic [STATUS_W-1:0] sticky_nxt;
	logic access;
	logic wr;
	logic rd;
	logic hit;
	logic irq_read;
	logic [STATUS_W-1:0] event_bits;
	logic no_event;

	assign src = '{CAL_DONE_I, HOLDOVER_ACTIVE_I, SECONDARY_REF_IN_USE_I,
		VCO_ABOVE_I, SEC_FREQ_ABOVE_I};

	// ----------------------------------------
	// live status word assembly
	// ----------------------------------------
	always_comb begin
		now_word = STATUS_RESET;
		now_word[CAL_DONE_BIT] = src.cal_done;
		now_word[HOLDOVER_BIT] = src.holdover_active;
		now_word[SEC_REF_BIT] = src.secondary_ref_in_use;
		now_word[VCO_HIGH_BIT] = src.vco_above;
		now_word[SEC_FREQ_BIT] = src.sec_freq_above;
	end

	assign access = PSEL_I & PENABLE_I;
	assign wr = access & PWRITE_I;
	assign rd = access & ~PWRITE_I;
	assign hit = (PADDR_I == STATUS_WORD_ADDR) || (PADDR_I == THRESH_CFG_ADDR)
		|| (PADDR_I == IRQ_STATUS_ADDR) || (PADDR_I == IRQ_MASK_ADDR);
	assign irq_read = rd & (PADDR_I == IRQ_STATUS_ADDR);
	assign event_bits = (now_word ^ r.live) & EVENT_FIELDS;
	assign no_event = (event_bits == 8'h00);

	status_event_cell #(
		.WIDTH(STATUS_W)
	) u_events (
		.now_i(now_word),
		.last_i(r.live),
		.sticky_i(r.sticky),
		.clear_i(irq_read),
		.sticky_nxt_o(sticky_nxt)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_nxt = r;
		r_nxt.live = now_word;
		r_nxt.sticky = sticky_nxt;
		if (wr && PSTRB_I[0]) begin
			if (PADDR_I == IRQ_MASK_ADDR) begin
				r_nxt.mask = PWDATA_I[7:0] & EVENT_FIELDS;
			end else if (PADDR_I == THRESH_CFG_ADDR) begin
				r_nxt.thresh_cfg = PWDATA_I[7:0];
			end
		end
		// the status word address has no write path at all
		if (rd) begin
			case (PADDR_I)
				STATUS_WORD_ADDR: r_nxt.prdata = {24'h000000, now_word};
				THRESH_CFG_ADDR: r_nxt.prdata = {24'h000000, r.thresh_cfg};
				IRQ_STATUS_ADDR: r_nxt.prdata = {24'h000000, r.sticky};
				IRQ_MASK_ADDR: r_nxt.prdata = {24'h000000, r.mask};
				default: r_nxt.prdata = 32'h00000000;
			endcase
		end
		r_nxt.irq = |(sticky_nxt & r_nxt.mask);
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			r <= '{STATUS_RESET, STATUS_RESET, MASK_RESET, THRESH_RESET,
				32'h00000000, 1'b0};
		end else begin
			r <= r_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// read data is live in the access cycle so the zero-wait answer is exact
	always_comb begin
		PRDATA_O = r.prdata;
		if (rd) begin
			case (PADDR_I)
				STATUS_WORD_ADDR: PRDATA_O = {24'h000000, now_word};
				THRESH_CFG_ADDR: PRDATA_O = {24'h000000, r.thresh_cfg};
				IRQ_STATUS_ADDR: PRDATA_O = {24'h000000, r.sticky};
				IRQ_MASK_ADDR: PRDATA_O = {24'h000000, r.mask};
				default: PRDATA_O = 32'h00000000;
			endcase
		end
	end
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = access & (~hit | (PWRITE_I & (PADDR_I == STATUS_WORD_ADDR)));
	assign THRESH_SEL_O = r.thresh_cfg[THRESH_SEL_BIT];
	assign IRQ_O = r.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	sequence s_status_read;
		rd && (PADDR_I == STATUS_WORD_ADDR);
	endsequence

	sequence s_status_write;
		wr && (PADDR_I == STATUS_WORD_ADDR);
	endsequence

	sequence s_thresh_write;
		wr && PSTRB_I[0] && (PADDR_I == THRESH_CFG_ADDR);
	endsequence

	sequence s_thresh_read;
		rd && (PADDR_I == THRESH_CFG_ADDR);
	endsequence

	sequence s_irq_read;
		rd && (PADDR_I == IRQ_STATUS_ADDR);
	endsequence

	sequence s_mask_write;
		wr && PSTRB_I[0] && (PADDR_I == IRQ_MASK_ADDR);
	endsequence

	sequence s_unmapped;
		access && !hit;
	endsequence

	a_cal_done_bit: assert property (s_status_read |-> PRDATA_O[6] == CAL_DONE_I)
		else $error("calibration-done bit wrong");
	a_cal_zero_low: assert property ((s_status_read and !CAL_DONE_I) |-> !PRDATA_O[6])
		else $error("calibration-done set too early");
	a_holdover_bit: assert property (s_status_read |-> PRDATA_O[5] == HOLDOVER_ACTIVE_I)
		else $error("holdover bit wrong");
	a_holdover_live: assert property ((s_status_read and !HOLDOVER_ACTIVE_I)
		|-> !PRDATA_O[5])
		else $error("holdover bit not live");
	a_ref_select_bit: assert property (s_status_read
		|-> PRDATA_O[4] == SECONDARY_REF_IN_USE_I)
		else $error("reference select bit wrong");
	a_vco_freq_bit: assert property (s_status_read |-> PRDATA_O[3] == VCO_ABOVE_I)
		else $error("vco frequency bit wrong");
	a_sec_freq_bit: assert property (s_status_read |-> PRDATA_O[2] == SEC_FREQ_ABOVE_I)
		else $error("secondary frequency bit wrong");
	a_thresh_sel_out: assert property (wr && PSTRB_I[0] && (PADDR_I == THRESH_CFG_ADDR)
		|=> THRESH_SEL_O == $past(PWDATA_I[6]))
		else $error("threshold select not applied");
	a_write_ignored: assert property (wr && (PADDR_I == STATUS_WORD_ADDR)
		|=> $stable(r.mask) && $stable(r.thresh_cfg))
		else $error("status write changed state");
	a_irq_level: assert property (##1 IRQ_O == |(r.sticky & r.mask))
		else $error("interrupt level wrong");

	// ----------------------------------------
	// status word layout, both levels of bits 4 to 2, set level of bits 6 and 5
	// ----------------------------------------
	a_status_upper_zero: assert property (s_status_read
		|-> (PRDATA_O[31:7] == 25'h0000000) && (PRDATA_O[1:0] == 2'b00))
		else $error("unused status bits not zero");
	a_cal_done_set: assert property ((s_status_read and CAL_DONE_I)
		|-> PRDATA_O[CAL_DONE_BIT])
		else $error("calibration-done bit missing");
	a_holdover_set: assert property ((s_status_read and HOLDOVER_ACTIVE_I)
		|-> PRDATA_O[HOLDOVER_BIT])
		else $error("holdover bit missing");
	a_ref_primary: assert property ((s_status_read and !SECONDARY_REF_IN_USE_I)
		|-> !PRDATA_O[SEC_REF_BIT])
		else $error("primary reference shown as secondary");
	a_ref_secondary: assert property ((s_status_read and SECONDARY_REF_IN_USE_I)
		|-> PRDATA_O[SEC_REF_BIT])
		else $error("secondary reference not shown");
	a_vco_below: assert property ((s_status_read and !VCO_ABOVE_I)
		|-> !PRDATA_O[VCO_HIGH_BIT])
		else $error("vco bit set while below");
	a_vco_above_set: assert property ((s_status_read and VCO_ABOVE_I)
		|-> PRDATA_O[VCO_HIGH_BIT])
		else $error("vco bit clear while above");
	a_sec_freq_below: assert property ((s_status_read and !SEC_FREQ_ABOVE_I)
		|-> !PRDATA_O[SEC_FREQ_BIT])
		else $error("secondary frequency bit set while below");
	a_sec_freq_set: assert property ((s_status_read and SEC_FREQ_ABOVE_I)
		|-> PRDATA_O[SEC_FREQ_BIT])
		else $error("secondary frequency bit clear while above");

	// ----------------------------------------
	// every change of a live status level is logged
	// ----------------------------------------
	a_cal_event: assert property ($past(RSTN_I) && $changed(CAL_DONE_I)
		|=> r.sticky[CAL_DONE_BIT])
		else $error("calibration change not logged");
	a_holdover_event: assert property ($past(RSTN_I) && $changed(HOLDOVER_ACTIVE_I)
		|=> r.sticky[HOLDOVER_BIT])
		else $error("holdover change not logged");
	a_ref_event: assert property ($past(RSTN_I) && $changed(SECONDARY_REF_IN_USE_I)
		|=> r.sticky[SEC_REF_BIT])
		else $error("reference change not logged");
	a_vco_event: assert property ($past(RSTN_I) && $changed(VCO_ABOVE_I)
		|=> r.sticky[VCO_HIGH_BIT])
		else $error("vco change not logged");
	a_sec_freq_event: assert property ($past(RSTN_I) && $changed(SEC_FREQ_ABOVE_I)
		|=> r.sticky[SEC_FREQ_BIT])
		else $error("secondary frequency change not logged");

	// ----------------------------------------
	// threshold select and read-only status word
	// ----------------------------------------
	a_thresh_readback: assert property (s_thresh_read
		|-> PRDATA_O[THRESH_SEL_BIT] == THRESH_SEL_O)
		else $error("threshold select readback wrong");
	a_thresh_write_ok: assert property (s_thresh_write
		|-> !PSLVERR_O)
		else $error("threshold write refused");
	a_status_write_err: assert property (s_status_write
		|-> PSLVERR_O)
		else $error("status write not refused");
	a_status_write_sel: assert property (s_status_write
		|=> $stable(THRESH_SEL_O))
		else $error("status write moved threshold select");
	a_status_write_irq: assert property ((s_status_write and no_event)
		|=> $stable(r.sticky))
		else $error("status write touched event log");
	a_read_keeps_sticky: assert property ((s_status_read and no_event)
		|=> $stable(r.sticky))
		else $error("status read touched event log");
	a_read_keeps_cfg: assert property (s_status_read
		|=> $stable(r.mask) && $stable(r.thresh_cfg))
		else $error("status read touched configuration");

	// ----------------------------------------
	// bus answers and interrupt bookkeeping
	// ----------------------------------------
	a_ready_zero_wait: assert property (access
		|-> PREADY_O)
		else $error("access not answered at once");
	a_unmapped_err: assert property (s_unmapped
		|-> PSLVERR_O)
		else $error("unmapped access not refused");
	a_unmapped_zero: assert property (s_unmapped and !PWRITE_I
		|-> PRDATA_O == 32'h00000000)
		else $error("unmapped read not zero");
	a_mapped_read_ok: assert property (rd && hit
		|-> !PSLVERR_O)
		else $error("mapped read refused");
	a_idle_no_err: assert property (!access
		|-> !PSLVERR_O)
		else $error("error outside access");
	a_read_high_zero: assert property (rd
		|-> PRDATA_O[31:8] == 24'h000000)
		else $error("read data upper bytes not zero");
	a_mask_write: assert property (s_mask_write
		|=> r.mask == ($past(PWDATA_I[7:0]) & EVENT_FIELDS))
		else $error("mask write not applied");
	a_mask_fields: assert property (1'b1
		|-> (r.mask & ~EVENT_FIELDS) == 8'h00)
		else $error("mask holds unused bits");
	a_sticky_fields: assert property (1'b1
		|-> (r.sticky & ~EVENT_FIELDS) == 8'h00)
		else $error("event log holds unused bits");
	a_irq_read_clear: assert property ((s_irq_read and no_event)
		|=> r.sticky == 8'h00)
		else $error("event log not cleared by read");
	a_irq_set_wins: assert property ((s_irq_read and !no_event)
		|=> (r.sticky & $past(event_bits)) == $past(event_bits))
		else $error("event lost to read clear");
	a_irq_masked_off: assert property (r.mask == 8'h00
		|-> !IRQ_O)
		else $error("interrupt while fully masked");

endmodule : loop_status_word

// ==== dv/tb_loop_status_word.sv ====
`timescale 1ns/1ps
module tb_loop_status_word;
	import loop_status_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [4:0] src = '0;
	logic pready, pslverr, thr, irq;
	logic [7:0] lfsr = 8'h4B;
	int failures = 0, compares = 0;
	int m_sticky = 0;
	int exp_q[$];
	logic [4:0] nxt;
	always #2 clk = ~clk;
	loop_status_word i_dut (.CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CAL_DONE_I(src[4]), .HOLDOVER_ACTIVE_I(src[3]),
		.SECONDARY_REF_IN_USE_I(src[2]), .VCO_ABOVE_I(src[1]), .SEC_FREQ_ABOVE_I(src[0]),
		.THRESH_SEL_O(thr), .IRQ_O(irq));
	function automatic logic [7:0] next_lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : next_lfsr
	function automatic logic [31:0] status_of(input logic [4:0] s);
		return {24'h000000, 1'b0, s, 2'b00};
	endfunction : status_of
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// apb master: setup, then access until pready
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			lfsr = next_lfsr(lfsr);
			nxt = lfsr[4:0];
			m_sticky = m_sticky | int'(status_of(src ^ nxt));
			exp_q.push_back(int'(status_of(nxt)));
			src <= nxt;
			apb(0, STATUS_WORD_ADDR, 0);
			check("status", rd, exp_q.pop_front());
		end
		apb(1, STATUS_WORD_ADDR, 32'hFFFF_FFFF);
		check("status write err", er, 1);
		apb(0, STATUS_WORD_ADDR, 0);
		check("status after write", rd, status_of(src));
		apb(1, THRESH_CFG_ADDR, 32'h40);
		repeat (2) @(posedge clk);
		check("thresh sel on", thr, 1);
		apb(1, THRESH_CFG_ADDR, 32'h00);
		repeat (2) @(posedge clk);
		check("thresh sel off", thr, 0);
		apb(0, 12'hFF0, 0);
		check("unmapped data", rd, 0);
		check("unmapped err", er, 1);
		// ----------------------------------------
		// interrupt: clear, raise, read-clear, mask
		// ----------------------------------------
		apb(1, IRQ_MASK_ADDR, 32'h7C);
		apb(0, IRQ_STATUS_ADDR, 0);
		check("irq backlog", rd, m_sticky);
		repeat (3) @(posedge clk);
		check("irq idle", irq, 0);
		src <= src ^ 5'h01;
		repeat (3) @(posedge clk);
		check("irq raised", irq, 1);
		apb(0, IRQ_STATUS_ADDR, 0);
		check("irq status", rd, 32'h04);
		repeat (3) @(posedge clk);
		check("irq cleared", irq, 0);
		apb(1, IRQ_MASK_ADDR, 32'h00);
		src <= src ^ 5'h10;
		repeat (3) @(posedge clk);
		check("irq masked", irq, 0);
		apb(0, IRQ_STATUS_ADDR, 0);
		check("masked sticky", rd, 32'h40);
		// ----------------------------------------
		// mid-run reset: configuration back to reset values
		// ----------------------------------------
		apb(1, THRESH_CFG_ADDR, 32'h40);
		apb(1, IRQ_MASK_ADDR, 32'h7C);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check("thresh sel reset", thr, 0);
		check("irq reset", irq, 0);
		apb(0, IRQ_MASK_ADDR, 0);
		check("mask reset", rd, 0);
		apb(0, THRESH_CFG_ADDR, 0);
		check("thresh reset", rd, 0);
		apb(0, STATUS_WORD_ADDR, 0);
		check("status after reset", rd, status_of(src));
		wrap_up();
	end
endmodule : tb_loop_status_word
